// ===== hw/ahb_consts.svh
`ifndef AHB_CONSTS_SVH
`define AHB_CONSTS_SVH

// Clock period in picoseconds (250 MHz)
`define AHB_CLK_PS 4000
// Least write strobe low time, ns
`define AHB_WR_PULSE_NS 250
`define AHB_WR_PULSE_CYC ((`AHB_WR_PULSE_NS * 1000 + `AHB_CLK_PS - 1) / `AHB_CLK_PS)
// Least delay from write strobe rise to read strobe fall, ns
`define AHB_WR_TO_RD_NS 250
`define AHB_WR_TO_RD_CYC ((`AHB_WR_TO_RD_NS * 1000 + `AHB_CLK_PS - 1) / `AHB_CLK_PS)
// Cycles before ready status is trusted after the read strobe falls
`define AHB_RDY_SETTLE_CYC 2
// Least read strobe low time after data is valid, ns
`define AHB_RD_HOLD_NS 20
`define AHB_RD_HOLD_CYC ((`AHB_RD_HOLD_NS * 1000 + `AHB_CLK_PS - 1) / `AHB_CLK_PS)
// Least conversion start spacing: 1 MHz maximum rate, ns
`define AHB_START_PERIOD_NS 1000
`define AHB_START_PERIOD_CYC ((`AHB_START_PERIOD_NS * 1000 + `AHB_CLK_PS - 1) / `AHB_CLK_PS)
// Result width and FIFO depth
`define AHB_DATA_W 8
`define AHB_FIFO_DEPTH 32
`define AHB_CNT_W 9

`endif

// ===== hw/ahb_pkg.sv
package ahb_pkg;
   // Controller states
   typedef enum logic [2:0] {
      AHB_IDLE,
      AHB_WR_LOW,
      AHB_WR_GAP,
      AHB_WAIT_DONE,
      AHB_RD_LOW,
      AHB_RD_END
   } ahb_state_t;

   // Strobes driven onto the converter
   typedef struct packed {
      logic cs_b;
      logic rd_b;
      logic wr_b;
   } ahb_strobe_t;

   // Status returned by the converter
   typedef struct packed {
      logic done_b;
      logic ready_b;
   } ahb_status_t;
endpackage

// ===== hw/ahb_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic push, pop;

   // Handshakes
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rp_r];

   // Pointer next values
   always_comb begin
      wp_nxt = push ? wp_r + AW'(1) : wp_r;
      rp_nxt = pop ? rp_r + AW'(1) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end

   // Pointer registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else if (clk_en) begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage
   always_ff @(posedge mclk) begin
      if (clk_en && push) begin
         mem[wp_r] <= in_data;
      end
   end
endmodule
`default_nettype wire

// ===== hw/ahb_host.sv
// Behaviour
// - Read mode: hold read low while ready status is low.
// - Read mode: conversion-complete low may end the access as acknowledge.
// - Write-read mode: write starts conversion, later read returns result.
// - Write-read mode: poll conversion-complete low before reading.
// - Write-read mode: conversion-complete triggers read pulse capturing result into a FIFO.
// - Conversions start from a precise timer, not software timing; here a start follows start_tick, gated by the gap counter and FIFO room.
// - Starts never faster than 1 MHz.
// - Mode low selects read mode; high selects write-read mode.
// - Write-read mode: read may fall 250 ns after write rises.
`timescale 1ns/1ps
`default_nettype none
`include "ahb_consts.svh"
module ahb_host (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic clk_en,
   // User side
   input wire logic mode_wr_rd,
   input wire logic start_tick,
   input wire logic early_read,
   output logic busy,
   output logic start_dropped,
   output logic sample_valid,
   input wire logic sample_ready,
   output logic [`AHB_DATA_W-1:0] sample_data,
   output logic sample_signed_b,
   input wire logic bipolar,
   // Converter pins
   output logic conv_mode,
   output ahb_pkg::ahb_strobe_t strobe,
   input wire ahb_pkg::ahb_status_t status,
   input wire logic [`AHB_DATA_W-1:0] result_bus
);
   ahb_pkg::ahb_state_t st_r, st_nxt;
   logic [`AHB_CNT_W-1:0] tmr_r, tmr_nxt;
   logic [`AHB_CNT_W-1:0] gap_r, gap_nxt;
   logic mode_r, mode_nxt;
   logic pend_r, pend_nxt;
   logic early_r, early_nxt;
   logic drop_r, drop_nxt;
   logic [`AHB_DATA_W-1:0] cap_r, cap_nxt;
   logic cap_v_r, cap_v_nxt;
   logic fifo_in_ready, data_ok, done_seen, ok_start;
   logic rd_stall;
   logic [`AHB_CNT_W-1:0] rd_last;

   // Converter acknowledges: ready released high or complete driven low
   assign done_seen = !status.done_b;
   assign data_ok = status.ready_b || done_seen;
   assign ok_start = (gap_r == '0) && fifo_in_ready;
   assign busy = (st_r != ahb_pkg::AHB_IDLE);
   assign start_dropped = drop_r;
   assign sample_signed_b = !bipolar;
   assign conv_mode = mode_r;

   // Ready status judged only once the converter had time to pull it low
   assign rd_stall = !mode_r && (tmr_r == `AHB_CNT_W'(`AHB_RDY_SETTLE_CYC)) && !data_ok;
   assign rd_last = mode_r ? `AHB_CNT_W'(`AHB_RD_HOLD_CYC) :
      `AHB_CNT_W'(`AHB_RDY_SETTLE_CYC + `AHB_RD_HOLD_CYC);

   // Strobes decoded from state
   always_comb begin
      strobe.cs_b = 1'b1;
      strobe.rd_b = 1'b1;
      strobe.wr_b = 1'b1;
      case (st_r)
         ahb_pkg::AHB_WR_LOW: begin
            strobe.cs_b = 1'b0;
            strobe.wr_b = 1'b0;
         end
         ahb_pkg::AHB_RD_LOW: begin
            strobe.cs_b = 1'b0;
            strobe.rd_b = 1'b0;
         end
         default: begin
            strobe.cs_b = 1'b1;
         end
      endcase
   end

   // Sequencer next state
   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      gap_nxt = (gap_r != '0) ? gap_r - `AHB_CNT_W'(1) : gap_r;
      mode_nxt = mode_r;
      pend_nxt = pend_r || (start_tick && st_r == ahb_pkg::AHB_IDLE);
      early_nxt = early_r;
      drop_nxt = 1'b0;
      cap_nxt = cap_r;
      cap_v_nxt = 1'b0;
      if (start_tick && (pend_r || st_r != ahb_pkg::AHB_IDLE)) begin
         drop_nxt = 1'b1;
      end
      case (st_r)
         ahb_pkg::AHB_IDLE: begin
            if (pend_r && ok_start) begin
               pend_nxt = 1'b0; // A tick in this cycle is refused and flagged
               mode_nxt = mode_wr_rd;
               early_nxt = early_read;
               gap_nxt = `AHB_CNT_W'(`AHB_START_PERIOD_CYC - 1);
               tmr_nxt = '0;
               st_nxt = mode_wr_rd ? ahb_pkg::AHB_WR_LOW : ahb_pkg::AHB_RD_LOW;
            end else if (!pend_r) begin
               mode_nxt = mode_wr_rd;
            end
         end
         ahb_pkg::AHB_WR_LOW: begin
            tmr_nxt = tmr_r + `AHB_CNT_W'(1);
            if (tmr_r >= `AHB_CNT_W'(`AHB_WR_PULSE_CYC - 1)) begin
               tmr_nxt = '0;
               st_nxt = early_r ? ahb_pkg::AHB_WR_GAP : ahb_pkg::AHB_WAIT_DONE;
            end
         end
         ahb_pkg::AHB_WR_GAP: begin
            tmr_nxt = tmr_r + `AHB_CNT_W'(1);
            if (tmr_r >= `AHB_CNT_W'(`AHB_WR_TO_RD_CYC - 1)) begin
               tmr_nxt = '0;
               st_nxt = ahb_pkg::AHB_RD_LOW;
            end
         end
         ahb_pkg::AHB_WAIT_DONE: begin
            if (done_seen) begin
               tmr_nxt = '0;
               st_nxt = ahb_pkg::AHB_RD_LOW;
            end
         end
         ahb_pkg::AHB_RD_LOW: begin
            // Read mode stalls at the settle point on ready status; write-read reads at once
            if (!rd_stall) begin
               tmr_nxt = tmr_r + `AHB_CNT_W'(1);
            end
            if (tmr_r >= rd_last) begin
               cap_nxt = result_bus;
               cap_v_nxt = 1'b1;
               tmr_nxt = '0;
               st_nxt = ahb_pkg::AHB_RD_END;
            end
         end
         ahb_pkg::AHB_RD_END: begin
            st_nxt = ahb_pkg::AHB_IDLE;
         end
         default: begin
            st_nxt = ahb_pkg::AHB_IDLE;
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ahb_pkg::AHB_IDLE;
         tmr_r <= '0;
         gap_r <= '0;
         mode_r <= 1'b0;
         pend_r <= 1'b0;
         early_r <= 1'b0;
         drop_r <= 1'b0;
         cap_r <= '0;
         cap_v_r <= 1'b0;
      end else if (clk_en) begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         gap_r <= gap_nxt;
         mode_r <= mode_nxt;
         pend_r <= pend_nxt;
         early_r <= early_nxt;
         drop_r <= drop_nxt;
         cap_r <= cap_nxt;
         cap_v_r <= cap_v_nxt;
      end
   end

   // Result FIFO; a start waits for room so no capture is lost
   ahb_fifo #(
      .WIDTH(`AHB_DATA_W),
      .DEPTH(`AHB_FIFO_DEPTH)
   ) u_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .in_valid(cap_v_r),
      .in_ready(fifo_in_ready),
      .in_data(cap_r),
      .out_valid(sample_valid),
      .out_ready(sample_ready),
      .out_data(sample_data)
   );

   // Start spacing never below the 1 MHz period
   start_rate_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_r == ahb_pkg::AHB_IDLE && st_nxt != ahb_pkg::AHB_IDLE && clk_en)
      |-> gap_r == '0 && gap_nxt == `AHB_CNT_W'(`AHB_START_PERIOD_CYC - 1))
      else $error("start spacing counter not loaded");
   write_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
      $fell(strobe.wr_b) |-> strobe.cs_b == 1'b0)
      else $error("write strobe without chip select");
   rd_select_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !strobe.rd_b |-> !strobe.cs_b && strobe.wr_b)
      else $error("read strobe without chip select");
   wr_rd_gap_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_r == ahb_pkg::AHB_WR_GAP && clk_en) |-> strobe.rd_b && strobe.wr_b)
      else $error("strobe active in write to read gap");
   read_wait_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_r == ahb_pkg::AHB_RD_LOW && !mode_r && clk_en && !data_ok &&
       tmr_r == `AHB_CNT_W'(`AHB_RDY_SETTLE_CYC))
      |=> !strobe.rd_b && tmr_r == `AHB_CNT_W'(`AHB_RDY_SETTLE_CYC))
      else $error("read released while converter holds wait");
   poll_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_r == ahb_pkg::AHB_WAIT_DONE && status.done_b) |=> strobe.rd_b)
      else $error("read before conversion complete");
   capture_push_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (clk_en && st_r == ahb_pkg::AHB_RD_END) |-> cap_v_r)
      else $error("captured result not pushed");
   mode_pin_a: assert property (@(posedge mclk) disable iff (!rst_b)
      (st_r == ahb_pkg::AHB_WR_LOW) |-> conv_mode)
      else $error("write strobe in read mode");
endmodule
`default_nettype wire

// ===== sim/ahb_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_conv_model #(
   parameter int CONV = 165
) (
   // Clock for timing only
   input wire logic mclk,
   // Converter pins
   input wire logic conv_mode,
   input wire ahb_pkg::ahb_strobe_t strobe,
   output ahb_pkg::ahb_status_t status,
   output logic [7:0] result_bus,
   // Input level as a code
   input wire logic [7:0] code
);
   logic [7:0] held = 8'h00;
   logic [7:0] last = 8'h00;
   logic run = 1'b0;
   logic done_b_r = 1'b1;
   logic ready_b_r = 1'b1;
   int cnt = 0;
   ahb_pkg::ahb_strobe_t prev = 3'h7;
   // Status lines; a released ready line reads high through its pull-up
   assign status = {done_b_r, ready_b_r};
   // Start, conversion end, early read and release of the complete line
   always @(posedge mclk) begin
      prev <= strobe;
      if (!strobe.cs_b && ((conv_mode && prev.wr_b && !strobe.wr_b) ||
          (!conv_mode && (prev.rd_b || prev.cs_b) && !strobe.rd_b))) begin
         held <= code;
         run <= 1;
         cnt <= CONV;
         ready_b_r <= conv_mode;
      end else if (run) begin
         if (cnt == 0) begin
            run <= 0;
            done_b_r <= 0;
            ready_b_r <= 1;
         end else begin
            cnt <= cnt - 1;
         end
      end
      if (conv_mode && run && prev.rd_b && !strobe.rd_b && !strobe.cs_b) begin
         run <= 0;
         done_b_r <= 0;
      end
      if ((!prev.rd_b && strobe.rd_b) || (!prev.cs_b && strobe.cs_b)) begin
         done_b_r <= 1;
      end
      if (!strobe.cs_b && !strobe.rd_b && !run) begin
         last <= held;
      end
   end
   // Drive only while selected and read, else a changed value
   always_comb begin
      result_bus = (!strobe.cs_b && !strobe.rd_b && !run) ? held : ~last;
   end
endmodule
`default_nettype wire

// ===== sim/ahb_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ahb_host_bench;
   logic mclk = 0;
   logic rst_b = 0;
   logic mode_wr_rd = 0;
   logic start_tick = 0;
   logic early_read = 0;
   logic sample_ready = 0;
   logic bipolar = 0;
   logic hold_all = 0;
   logic clk_en = 1;
   logic [7:0] code = 8'h00;
   logic busy, start_dropped, sample_valid, sample_signed_b, conv_mode;
   logic [7:0] sample_data, result_bus;
   ahb_pkg::ahb_strobe_t strobe;
   ahb_pkg::ahb_status_t status;
   int error_cnt = 0;
   int n_compared = 0;
   logic [7:0] exp_q[$];
   always #2 mclk = ~mclk;
   ahb_host i_ahb_host (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .mode_wr_rd(mode_wr_rd),
      .start_tick(start_tick), .early_read(early_read), .busy(busy),
      .start_dropped(start_dropped), .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_data(sample_data), .sample_signed_b(sample_signed_b), .bipolar(bipolar),
      .conv_mode(conv_mode), .strobe(strobe), .status(status), .result_bus(result_bus));
   ahb_conv_model i_ahb_conv_model (.mclk(mclk), .conv_mode(conv_mode), .strobe(strobe),
      .status(status), .result_bus(result_bus), .code(code));
   task automatic check(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Stalling drain side
   always @(posedge mclk) begin
      sample_ready <= hold_all ? 1'b0 : 1'($urandom);
   end
   // Compare each drained byte with the expected queue
   always @(posedge mclk) begin
      if (rst_b && sample_valid && sample_ready) begin
         check(exp_q.size() > 0 && sample_data === exp_q[0], "sample data");
         if (exp_q.size() > 0) void'(exp_q.pop_front());
      end
   end
   // One conversion, with an optional refused second start
   task automatic convert(input logic m, input logic e, input logic dup);
      int t;
      @(posedge mclk);
      code <= 8'($urandom);
      bipolar <= 1'($urandom);
      mode_wr_rd <= m;
      early_read <= e;
      start_tick <= 1;
      @(posedge mclk);
      start_tick <= 0;
      exp_q.push_back(code);
      @(posedge mclk);
      #1;
      check(busy === 1 && strobe.cs_b === 0 && (m ? strobe.wr_b : strobe.rd_b) === 0,
         "start strobes");
      check(conv_mode === m && sample_signed_b === ~bipolar, "mode or coding");
      if (dup) begin
         @(posedge mclk) start_tick <= 1;
         @(posedge mclk) start_tick <= 0;
         #1;
         check(start_dropped === 1, "second start not refused");
      end
      t = 0;
      while (busy !== 0 && t < 2000) begin
         @(posedge mclk);
         t++;
      end
      check(busy === 0, "conversion hung");
      repeat (250) @(posedge mclk);
   endtask
   initial begin
      #300000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      void'($urandom(50));
      repeat (3) @(posedge mclk);
      rst_b <= 1;
      // Every mode and read option, back to back
      for (int i = 0; i < 12; i++) convert(1'(i % 2), 1'(i / 2 % 2), 1'(i % 3 == 0));
      // Fill the buffer with the drain stalled, then check the fill
      hold_all <= 1;
      repeat (32) convert(1'($urandom), 1'($urandom), 0);
      #1;
      check(sample_valid === 1 && exp_q.size() == 32, "buffer fill");
      // Reset between conversions with the buffer full flushes it and parks every strobe
      @(posedge mclk) rst_b <= 0;
      repeat (3) @(posedge mclk);
      #1;
      check(busy === 0 && sample_valid === 0 && strobe === 3'h7 && conv_mode === 0,
         "reset state");
      exp_q.delete();
      @(posedge mclk) rst_b <= 1;
      // A start while frozen is not taken
      clk_en <= 0;
      start_tick <= 1;
      @(posedge mclk) start_tick <= 0;
      repeat (3) @(posedge mclk);
      clk_en <= 1;
      #1;
      check(busy === 0 && strobe === 3'h7, "start taken while frozen");
      hold_all <= 0;
      // Starts right after reset, read mode then early write-read
      convert(0, 0, 0);
      convert(1, 1, 1);
      repeat (2000) @(posedge mclk);
      #1;
      check(sample_valid === 0 && exp_q.size() == 0, "buffer drain");
      end_of_test();
   end
endmodule
`default_nettype wire
